// [hdl/lcr_receiver.sv]
// Receiver state sequencer and indicator driver with an APB register slave.
// Assumes beam status, sync and fault inputs are synchronous to pclk.
`timescale 1ns/10ps
`include "lcr_regs.svh"
module lcr_receiver #(
  parameter int unsigned FLASH_CYC = `LCR_FLASH_CYC,
  parameter int unsigned STEP_CYC = `LCR_STEP_CYC,
  parameter int unsigned TEST_CYC = `LCR_TEST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] beam_blocked,
  input wire logic sync_valid,
  input wire logic self_test_fail,
  input wire logic critical_fault,
  output logic safety_output_pair_1,
  output logic safety_output_pair_2,
  output lcr_pkg::lcr_lamp_e status_lamp,
  output logic run_lamp,
  output lcr_pkg::lcr_lamp_e zone_lamp [8],
  output logic [3:0] display_digit,
  output logic scanning,
  output logic irq
);
  import lcr_pkg::*;

  // ==========================================================================
  // Declarations
  lcr_state_e state_q, state_d;
  logic [31:0] ctrl_q;
  logic [`LCR_IRQ_W-1:0] irq_q, mask_q, ev;
  logic [31:0] tmr_q;
  logic [31:0] flash_q;
  logic flash_ph_q;
  logic [2:0] step_q;
  logic [3:0] ecode_q;
  logic [6:0] blk_cnt;
  logic [7:0] zone_blk;
  logic outputs_on;
  logic wr_en, rd_en;
  logic [31:0] rd_val;
  logic addr_ok;
  logic fault_in;

  lcr_beam_count u_count (
    .beam_blocked(beam_blocked),
    .blocked_count(blk_cnt),
    .zone_blocked(zone_blk)
  );

  function automatic lcr_lamp_e lamp_of(input logic red);
    return red ? LCR_LAMP_RED : LCR_LAMP_GREEN;
  endfunction

  // ==========================================================================
  // APB slave: zero wait states, unmapped addresses answer with pslverr
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign fault_in = critical_fault | ctrl_q[`LCR_CTRL_FAULT_BIT];

  always_comb begin
    rd_val = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == `LCR_CTRL_OFF) begin
      rd_val = ctrl_q;
    end else if (paddr == `LCR_STAT_OFF) begin
      rd_val = {20'h00000, ecode_q, 1'b0, safety_output_pair_1, run_lamp, scanning, 1'b0,
                state_q};
    end else if (paddr == `LCR_BEAM_OFF) begin
      rd_val = {17'h00000, blk_cnt, zone_blk};
    end else if (paddr == `LCR_IRQ_OFF) begin
      rd_val = {27'h0000000, irq_q};
    end else if (paddr == `LCR_MASK_OFF) begin
      rd_val = {27'h0000000, mask_q};
    end else if (paddr == `LCR_DISP_OFF) begin
      rd_val = {28'h0000000, display_digit};
    end else if (paddr == `LCR_LAMP_OFF) begin
      rd_val = {26'h0000000, run_lamp, 1'b0, 2'(status_lamp), 2'b00};
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `LCR_CTRL_RST;
    end else if (wr_en && paddr == `LCR_CTRL_OFF) begin
      ctrl_q <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `LCR_MASK_RST;
    end else if (wr_en && paddr == `LCR_MASK_OFF) begin
      mask_q <= pwdata[`LCR_IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // State sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      LCR_POWERUP: begin
        if (tmr_q >= TEST_CYC - 1 && self_test_fail | fault_in) begin
          state_d = LCR_LOCKOUT;
        end else if (step_q == 3'(2 * `LCR_SCAN_REPEATS)) begin
          state_d = LCR_ALIGN;
        end
      end
      LCR_ALIGN: begin
        if (fault_in) begin
          state_d = LCR_LOCKOUT;
        end else if (sync_valid && blk_cnt == 7'h00) begin
          state_d = LCR_RUN;
        end
      end
      LCR_RUN: begin
        if (fault_in) begin
          state_d = LCR_LOCKOUT;
        end
      end
      default: state_d = LCR_LOCKOUT;
    endcase
  end

  // Lockout only leaves by power cycle, i.e. reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= LCR_POWERUP;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecode_q <= 4'h0;
    end else if (state_q != LCR_LOCKOUT && state_d == LCR_LOCKOUT) begin
      ecode_q <= self_test_fail ? 4'h1 : ctrl_q[`LCR_CTRL_ECODE_LSB +: 4];
    end
  end

  // ==========================================================================
  // Timers: self-test, scan code steps, flash phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= 32'h0000_0000;
      step_q <= 3'h0;
    end else if (state_q != LCR_POWERUP) begin
      tmr_q <= 32'h0000_0000;
      step_q <= 3'h0;
    end else if (tmr_q >= STEP_CYC - 1) begin
      tmr_q <= 32'h0000_0000;
      step_q <= step_q + 3'h1;
    end else begin
      tmr_q <= tmr_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_q <= 32'h0000_0000;
      flash_ph_q <= 1'b0;
    end else if (flash_q >= FLASH_CYC - 1) begin
      flash_q <= 32'h0000_0000;
      flash_ph_q <= ~flash_ph_q;
    end else begin
      flash_q <= flash_q + 32'h1;
    end
  end

  // ==========================================================================
  // Safety outputs: combinational so a blocked beam drops them the same cycle
  assign outputs_on = (state_q == LCR_RUN) && (blk_cnt == 7'h00) && !fault_in;
  assign safety_output_pair_1 = outputs_on;
  assign safety_output_pair_2 = outputs_on;
  assign scanning = (state_q == LCR_ALIGN) || (state_q == LCR_RUN);
  assign run_lamp = (state_q == LCR_RUN);

  // ==========================================================================
  // Lamps and display
  always_comb begin
    case (state_q)
      LCR_POWERUP: status_lamp = (step_q == 3'h0) ? LCR_LAMP_RED : LCR_LAMP_OFF;
      LCR_LOCKOUT: status_lamp = flash_ph_q ? LCR_LAMP_RED : LCR_LAMP_OFF;
      default: status_lamp = outputs_on ? LCR_LAMP_GREEN : LCR_LAMP_RED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int z = 0; z < 8; z++) begin
        zone_lamp[z] <= LCR_LAMP_OFF;
      end
    end else begin
      for (int z = 0; z < 8; z++) begin
        case (state_q)
          LCR_POWERUP: zone_lamp[z] <= (step_q == 3'h0) ? LCR_LAMP_RED : LCR_LAMP_OFF;
          LCR_ALIGN: begin
            if (beam_blocked[0]) begin
              zone_lamp[z] <= (z == 0) ? LCR_LAMP_RED : LCR_LAMP_OFF;
            end else begin
              zone_lamp[z] <= lamp_of(zone_blk[z]);
            end
          end
          LCR_RUN: zone_lamp[z] <= lamp_of(zone_blk[z]);
          default: zone_lamp[z] <= LCR_LAMP_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_digit <= `LCR_DISP_BLANK;
    end else begin
      case (state_q)
        LCR_POWERUP: begin
          // Even steps show the code, odd steps blank: three flashes.
          // The hand-over step to alignment stays blank, else a fourth flash shows.
          if (step_q[0] || step_q >= 3'(2 * `LCR_SCAN_REPEATS)) begin
            display_digit <= `LCR_DISP_BLANK;
          end else begin
            display_digit <= ctrl_q[`LCR_CTRL_SCAN_LSB +: 4];
          end
        end
        LCR_ALIGN: begin
          if (beam_blocked[0]) begin
            display_digit <= `LCR_DISP_SYNC;
          end else begin
            display_digit <= (blk_cnt > 7'h09) ? 4'h9 : blk_cnt[3:0];
          end
        end
        LCR_RUN: begin
          if (blk_cnt == 7'h00) begin
            display_digit <= `LCR_DISP_RUN;
          end else begin
            // One digit only: counts above nine saturate
            display_digit <= (blk_cnt > 7'h09) ? 4'h9 : blk_cnt[3:0];
          end
        end
        default: display_digit <= ecode_q;
      endcase
    end
  end

  // ==========================================================================
  // Sticky event flags, cleared by reading; a new event wins over the clear
  assign ev[`LCR_IRQ_ALIGN_BIT] = (state_q == LCR_POWERUP) && (state_d == LCR_ALIGN);
  assign ev[`LCR_IRQ_RUN_BIT] = (state_q == LCR_ALIGN) && (state_d == LCR_RUN);
  assign ev[`LCR_IRQ_TRIP_BIT] = (state_q == LCR_RUN) && (blk_cnt != 7'h00);
  assign ev[`LCR_IRQ_CLEAR_BIT] = (state_q == LCR_RUN) && outputs_on;
  assign ev[`LCR_IRQ_LOCK_BIT] = (state_q != LCR_LOCKOUT) && (state_d == LCR_LOCKOUT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= '0;
    end else if (rd_en && paddr == `LCR_IRQ_OFF) begin
      // Clear only what the read returned, so an event of the setup cycle survives
      irq_q <= (irq_q & ~prdata[`LCR_IRQ_W-1:0]) | ev;
    end else begin
      irq_q <= irq_q | ev;
    end
  end

  assign irq = |(irq_q & mask_q);
endmodule

// [pkg/lcr_regs.svh]
// Register offsets, field positions, reset values and timing counts for the
// light curtain receiver sequencer. Assumes a 200 MHz pclk.
`ifndef LCR_REGS_SVH
`define LCR_REGS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define LCR_CTRL_OFF 12'h000
`define LCR_STAT_OFF 12'h004
`define LCR_BEAM_OFF 12'h008
`define LCR_IRQ_OFF 12'h00c
`define LCR_MASK_OFF 12'h010
`define LCR_DISP_OFF 12'h014
`define LCR_LAMP_OFF 12'h018

// ==========================================================================
// Field positions
`define LCR_CTRL_FAULT_BIT 0
`define LCR_CTRL_SCAN_LSB 4
`define LCR_CTRL_ECODE_LSB 8
`define LCR_IRQ_ALIGN_BIT 0
`define LCR_IRQ_RUN_BIT 1
`define LCR_IRQ_TRIP_BIT 2
`define LCR_IRQ_CLEAR_BIT 3
`define LCR_IRQ_LOCK_BIT 4
`define LCR_IRQ_W 5

// ==========================================================================
// Reset values and display codes
`define LCR_CTRL_RST 32'h0000_0000
`define LCR_MASK_RST 5'h00
`define LCR_DISP_BLANK 4'hf
`define LCR_DISP_SYNC 4'he
`define LCR_DISP_RUN 4'h8

// ==========================================================================
// Timing: flash half period 250 ms, scan code step 500 ms, self-test 1 ms
`define LCR_CLK_MHZ 200
`define LCR_FLASH_MS 250
`define LCR_STEP_MS 500
`define LCR_TEST_US 1000
`define LCR_FLASH_CYC (`LCR_FLASH_MS * 1000 * `LCR_CLK_MHZ)
`define LCR_STEP_CYC (`LCR_STEP_MS * 1000 * `LCR_CLK_MHZ)
`define LCR_TEST_CYC (`LCR_TEST_US * `LCR_CLK_MHZ)
`define LCR_SCAN_REPEATS 3

`endif

// [pkg/lcr_pkg.sv]
// Types for the light curtain receiver sequencer.
// Assumes lcr_regs.svh supplies all numeric constants.
package lcr_pkg;
  // Gray coded along power-up, align, run; lockout off the path
  typedef enum logic [2:0] {
    LCR_POWERUP = 3'b000,
    LCR_ALIGN = 3'b001,
    LCR_RUN = 3'b011,
    LCR_LOCKOUT = 3'b010
  } lcr_state_e;
  typedef enum logic [1:0] {
    LCR_LAMP_OFF = 2'b00,
    LCR_LAMP_GREEN = 2'b01,
    LCR_LAMP_RED = 2'b10
  } lcr_lamp_e;
endpackage

// [hdl/lcr_beam_count.sv]
// Counts blocked beams and folds the beam vector into eight zone flags.
// Assumes a 64-beam curtain, one beam bit per input, 1 = blocked.
`timescale 1ns/10ps
module lcr_beam_count (
  input wire logic [63:0] beam_blocked,
  output logic [6:0] blocked_count,
  output logic [7:0] zone_blocked
);
  import lcr_pkg::*;

  // ==========================================================================
  // Combinational count and zone fold
  always_comb begin
    blocked_count = 7'h00;
    zone_blocked = 8'h00;
    for (int i = 0; i < 64; i++) begin
      blocked_count = blocked_count + {6'h00, beam_blocked[i]};
      zone_blocked[i / 8] = zone_blocked[i / 8] | beam_blocked[i];
    end
  end
endmodule

// [verif/lcr_chk.sv]
// Port-level checker for the receiver sequencer.
// Assumes it is bound into lcr_receiver and sees only its ports.
`timescale 1ns/10ps
module lcr_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [63:0] beam_blocked,
  input wire logic critical_fault,
  input wire logic safety_output_pair_1,
  input wire logic safety_output_pair_2,
  input wire lcr_pkg::lcr_lamp_e status_lamp,
  input wire logic run_lamp,
  input wire lcr_pkg::lcr_lamp_e zone_lamp [8],
  input wire logic scanning
);
  import lcr_pkg::*;
  // ==========================================================
  // Sequences
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_align_b1;
    scanning && !run_lamp && beam_blocked[0];
  endsequence
  sequence s_run_clear;
    run_lamp && beam_blocked == 64'h0 && !critical_fault;
  endsequence
  // ==========================================================
  // Assertions
  a_green_when_on: assert property (safety_output_pair_1 |-> status_lamp == LCR_LAMP_GREEN)
    else $error("status lamp not green while outputs on");
  a_red_when_off: assert property (scanning && !safety_output_pair_1 |->
    status_lamp == LCR_LAMP_RED) else $error("status lamp not red while outputs off");
  a_run_lamp_mode: assert property (run_lamp |-> scanning)
    else $error("run lamp lit outside run mode");
  a_pair_agree: assert property (safety_output_pair_1 == safety_output_pair_2)
    else $error("output pair disagree");
  a_blocked_off: assert property (|beam_blocked |-> !safety_output_pair_1)
    else $error("outputs on with a beam blocked");
  a_idle_all_off: assert property (!scanning |-> !safety_output_pair_1 && !run_lamp)
    else $error("outputs or run lamp on while not scanning");
  a_fault_lockout: assert property (critical_fault |=> !scanning && !safety_output_pair_1)
    else $error("fault did not stop scanning");
  a_sync_zones: assert property (s_align_b1 |=> zone_lamp[0] == LCR_LAMP_RED &&
    zone_lamp[1] == LCR_LAMP_OFF && zone_lamp[7] == LCR_LAMP_OFF) else $error("zone lamps wrong");
  a_clear_on: assert property (s_run_clear |-> safety_output_pair_1)
    else $error("outputs off in clear run");
  a_clear_green: assert property (s_run_clear ##1 run_lamp |-> zone_lamp[4] == LCR_LAMP_GREEN)
    else $error("zone not green in clear run");
endmodule
bind lcr_receiver lcr_chk chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .beam_blocked(beam_blocked),
  .critical_fault(critical_fault),
  .safety_output_pair_1(safety_output_pair_1),
  .safety_output_pair_2(safety_output_pair_2),
  .status_lamp(status_lamp),
  .run_lamp(run_lamp),
  .zone_lamp(zone_lamp),
  .scanning(scanning)
);

// [verif/lcr_machine.sv]
// Model of the guarded machine control circuit.
// Assumes both safety outputs high mean the machine may run.
`timescale 1ns/10ps
module lcr_machine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic out_1,
  input wire logic out_2,
  input wire logic start,
  output logic machine_run_q
);
  // ==========================================================
  // Restart interlock: receiver restores outputs on its own, so a start is needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      machine_run_q <= 1'b0;
    end else if (!(out_1 && out_2)) begin
      machine_run_q <= 1'b0;
    end else if (start) begin
      machine_run_q <= 1'b1;
    end
  end
endmodule

// [verif/lcr_receiver_tb.sv]
// Self-checking bench for the receiver sequencer.
// Assumes shortened counts FLASH_CYC=4, STEP_CYC=8, TEST_CYC=4.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module lcr_receiver_tb;
  import lcr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic sync_valid = 0, self_test_fail = 0, critical_fault = 0, start = 0;
  logic pready, pslverr, o1, o2, run_lamp, scanning, irq, mrun, e, a;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [63:0] beam_blocked = 64'h0;
  logic [3:0] display_digit, pd;
  lcr_lamp_e status_lamp;
  lcr_lamp_e zone_lamp [8];
  int bad_count = 0, checked = 0, cyc = 0, n;
  lcr_receiver #(.FLASH_CYC(4), .STEP_CYC(8), .TEST_CYC(4)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .beam_blocked(beam_blocked), .sync_valid(sync_valid), .self_test_fail(self_test_fail),
    .critical_fault(critical_fault), .safety_output_pair_1(o1), .safety_output_pair_2(o2),
    .status_lamp(status_lamp), .run_lamp(run_lamp), .zone_lamp(zone_lamp),
    .display_digit(display_digit), .scanning(scanning), .irq(irq));
  lcr_machine mach_u (.clk(pclk), .rst_n(presetn), .out_1(o1), .out_2(o2), .start(start),
    .machine_run_q(mrun));
  // ==========================================================
  // Clock, timeout, helpers
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask
  task clk1;
    @(posedge pclk); #1;
  endtask
  task do_reset;
    @(posedge pclk); presetn <= 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
  endtask
  // ==========================================================
  // Scenarios
  task t_powerup;
    #1 `CHK(status_lamp, LCR_LAMP_RED)
    apb(1, 12'h000, 32'h0000_0730);
    #1 `CHK(zone_lamp[3], LCR_LAMP_RED)
    n = 0;
    pd = 4'hx;
    for (int i = 0; i < 100 && scanning !== 1'b1; i++) begin
      clk1;
      if (display_digit === 4'h3 && pd !== 4'h3) n++;
      pd = display_digit;
    end
    `CHK(n, 3)
    `CHK(scanning, 1'b1)
  endtask
  task t_align;
    @(posedge pclk); beam_blocked <= 64'h1; clk1;
    `CHK(zone_lamp[0], LCR_LAMP_RED)
    `CHK(zone_lamp[7], LCR_LAMP_OFF)
    @(posedge pclk); beam_blocked <= 64'h600; clk1;
    `CHK(display_digit, 4'h2)
    `CHK(zone_lamp[1], LCR_LAMP_RED)
    `CHK(zone_lamp[0], LCR_LAMP_GREEN)
    @(posedge pclk); beam_blocked <= 64'h0; sync_valid <= 1; clk1; clk1;
    `CHK(run_lamp, 1'b1)
    `CHK(status_lamp, LCR_LAMP_GREEN)
    `CHK(zone_lamp[5], LCR_LAMP_GREEN)
    `CHK(mrun, 1'b0)
    apb(0, 12'h00c, 32'h0);
    `CHK(r[1:0], 2'b11)
  endtask
  task t_run;
    @(posedge pclk); start <= 1;
    @(posedge pclk); start <= 0; clk1;
    `CHK(mrun, 1'b1)
    @(posedge pclk); beam_blocked <= 64'h1 << 20; #1;
    `CHK({o1, o2}, 2'b00)
    clk1;
    `CHK(display_digit, 4'h1)
    `CHK(zone_lamp[2], LCR_LAMP_RED)
    `CHK(run_lamp, 1'b1)
    @(posedge pclk); beam_blocked <= 64'h0; #1;
    `CHK({o1, o2}, 2'b11)
    clk1;
    `CHK(zone_lamp[2], LCR_LAMP_GREEN)
    `CHK(mrun, 1'b0)
  endtask
  task t_lock;
    @(posedge pclk); critical_fault <= 1; clk1; clk1;
    `CHK({scanning, run_lamp, o1}, 3'b000)
    `CHK(zone_lamp[0], LCR_LAMP_OFF)
    `CHK(display_digit, 4'h7)
    n = 0;
    repeat (12) begin
      clk1;
      if (status_lamp === LCR_LAMP_RED) n++;
    end
    `CHK(n > 0 && n < 12, 1'b1)
    apb(0, 12'h004, 32'h0);
    `CHK(r[11:8], 4'h7)
    apb(1, 12'h010, 32'h1f); clk1;
    a = irq;
    apb(1, 12'h010, 32'h0); clk1;
    `CHK(irq ^ a, 1'b1)
    apb(0, 12'h00c, 32'h0);
    `CHK(r[4], 1'b1)
    apb(1, 12'h010, 32'h1f); clk1;
    `CHK(irq, 1'b0)
    apb(0, 12'h01c, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0})
  endtask
  task t_selftest;
    @(posedge pclk); critical_fault <= 0; self_test_fail <= 1; sync_valid <= 0;
    do_reset;
    repeat (12) clk1;
    `CHK(display_digit, 4'h1)
    `CHK({scanning, o1}, 2'b00)
  endtask
  initial begin
    do_reset;
    t_powerup;
    t_align;
    t_run;
    t_lock;
    t_selftest;
    end_of_test;
  end
endmodule
